// file: common/desr_map.vh
// Constants for the drive ending status readout block
`ifndef DESR_MAP_VH
`define DESR_MAP_VH
// Status select codes
`define DESR_SEL_ENDING   2'h0
`define DESR_SEL_CYLINDER 2'h1
`define DESR_SEL_SECTHEAD 2'h2
`define DESR_SEL_BUSDATA  2'h3
// Parcel layout
`define DESR_INIT_HI      15
`define DESR_INIT_LO      8
`define DESR_FINAL_HI     7
`define DESR_FINAL_LO     0
// Ending status byte fields
`define DESR_OP_HI        3
`define DESR_OP_LO        0
`define DESR_BIT_TIMEDEP  4
`define DESR_BIT_ODD      5
`define DESR_BIT_PARITY   6
`define DESR_BIT_GOOD     7
// Operation status codes
`define DESR_OP_DONE      4'h0
`define DESR_OP_REJECT    4'h1
`define DESR_OP_NOAM      4'h4
`define DESR_OP_NOSYNC    4'h5
`define DESR_OP_ECC       4'h6
`define DESR_OP_IDMIS     4'h7
`define DESR_OP_EXCEPT    4'h8
`define DESR_OP_UNSOL     4'hC
// Reset values
`define DESR_RST_STATUS   8'h00
`define DESR_RST_PARCEL   16'h0000
// ID parameter 1 layout
`define DESR_SECT_W       6
`define DESR_HEAD_W       5
`define DESR_HEAD_LO      6
`define DESR_RP_BIT       12
`define DESR_WP_BIT       13
`endif

// file: logic/desr_status_capture.v
// Capture of initial and final ending status bytes from bus B
`timescale 1ns/1ps
`include "desr_map.vh"
module desr_status_capture (
    // Clock and reset
    input  wire       core_clk,
    input  wire       reset,
    // Sequencer events
    input  wire       seq_start,
    input  wire       seq_dual,
    input  wire       status_strobe,
    input  wire [7:0] bus_b_in,
    // Captured bytes and capture state
    output reg  [7:0] init_status_q,
    output reg  [7:0] final_status_q,
    output reg        second_pending_q,
    output reg        capture_done_q
);
    // ======================================================
    // Capture sequencing
    // ======================================================
    always @(posedge core_clk) begin
        if (reset) begin
            init_status_q    <= `DESR_RST_STATUS;
            final_status_q   <= `DESR_RST_STATUS;
            second_pending_q <= 1'b0;
            capture_done_q   <= 1'b0;
        end else begin
            capture_done_q <= 1'b0;
            if (status_strobe) begin
                if (second_pending_q) begin
                    final_status_q   <= bus_b_in; // [R3] [R6]
                    second_pending_q <= 1'b0;
                    capture_done_q   <= 1'b1;
                end else begin
                    init_status_q  <= bus_b_in; // [R5]
                    // Copy into the low byte too, so a single sequence reads doubled
                    final_status_q <= bus_b_in; // [R2]
                    second_pending_q <= seq_dual; // [R3]
                    capture_done_q <= ~seq_dual;
                end
            end else if (seq_start) begin
                second_pending_q <= 1'b0;
            end
        end
    end
endmodule

// file: logic/desr_readout.v
// Drive ending status readout: select-driven status parcel to the accumulator
//
// Operation
// [R1] Select 00 returns the ending status parcel to the accumulator.
// [R2] Single sequence puts the initial status byte in both parcel bytes.
// [R3] Dual sequence keeps first byte as initial, second as final.
// [R4] Initial byte in bits 15..8, final byte in bits 7..0.
// [R5] Initial byte is the bus B status at first sequence completion.
// [R6] Sector write: ID-compare status first, write-data status second.
// [R7] Drive encodes operation status codes 00,01,04,05,06,07 octal.
// [R8] Code 10 octal is operation exception, 14 unsolicited needing status read.
// [R9] Bit 4 means command still running; Attention In follows later.
// [R10] Bit 5 marks odd byte count; last bus B byte invalid.
// [R11] Drive sets bit 6 on detected bus parity error.
// [R12] Drive sets bit 7 when no parity error was found.
// [R13] Select 01 returns the ID parameter 0 parcel.
// [R14] ID parameter 0 parcel is the live cylinder register value.
// [R15] Select 10 returns sector and head addresses.
// [R16] Select 11 returns bus A byte high, bus B byte low.
// [R17] Reading never alters the stored status bytes.
`timescale 1ns/1ps
`include "desr_map.vh"
module desr_readout (
    // Clock and reset
    input  wire        core_clk,
    input  wire        reset,
    // Status-read channel function
    input  wire        status_read_function,
    input  wire [1:0]  status_select,
    // Sequencer and drive side
    input  wire        seq_start,
    input  wire        seq_dual,
    input  wire        status_strobe,
    input  wire [7:0]  bus_a_in,
    input  wire [7:0]  bus_b_in,
    // Adapter address registers
    input  wire [15:0] cylinder_reg,
    input  wire [5:0]  sector_addr,
    input  wire [4:0]  head_addr,
    input  wire        read_protect,
    input  wire        write_protect,
    // Accumulator side
    output reg  [15:0] accum_data_q,
    output reg         accum_valid_q,
    // Sequence done and decoded status of last ending status byte
    output reg         seq_done_q,
    output reg         op_exception_q,
    output reg         unsol_exception_q,
    output reg         cmd_pending_q,
    output reg         last_byte_invalid_q,
    output reg         parity_error_q,
    output reg         good_transfer_q
);
    // ======================================================
    // Status capture
    // ======================================================
    wire [7:0] init_status;
    wire [7:0] final_status;
    wire       capture_done;

    desr_status_capture u_capture (
        .core_clk         (core_clk),
        .reset            (reset),
        .seq_start        (seq_start),
        .seq_dual         (seq_dual),
        .status_strobe    (status_strobe),
        .bus_b_in         (bus_b_in),
        .init_status_q    (init_status),
        .final_status_q   (final_status),
        .second_pending_q (),
        .capture_done_q   (capture_done)
    );

    // ======================================================
    // Stored parcels
    // ======================================================
    // Both parcels are plain views of state; nothing on the read side writes back
    wire [15:0] drive_ending_status_parcel;
    wire [15:0] id_parameter_zero_status;

    assign drive_ending_status_parcel[`DESR_INIT_HI:`DESR_INIT_LO]   = init_status; // [R4]
    assign drive_ending_status_parcel[`DESR_FINAL_HI:`DESR_FINAL_LO] = final_status; // [R4]
    // Live value, so a read between cylinder moves sees the newest address
    assign id_parameter_zero_status = cylinder_reg; // [R14]

    // ======================================================
    // Field helpers
    // ======================================================
    function [15:0] desr_sect_head;
        input [5:0] sect;
        input [4:0] head;
        input       rp;
        input       wp;
        begin
            desr_sect_head = 16'h0000;
            desr_sect_head[`DESR_SECT_W-1:0] = sect;
            desr_sect_head[`DESR_HEAD_LO+`DESR_HEAD_W-1:`DESR_HEAD_LO] = head;
            desr_sect_head[`DESR_RP_BIT] = rp;
            desr_sect_head[`DESR_WP_BIT] = wp;
        end
    endfunction

    // True when the operation status field of a byte holds the given code
    function desr_op_match;
        input [7:0] status;
        input [3:0] code;
        begin
            desr_op_match = (status[`DESR_OP_HI:`DESR_OP_LO] == code);
        end
    endfunction

    // Picks one of the four parcels by the two select bits
    function [15:0] desr_pick;
        input [1:0]  sel;
        input [15:0] ending;
        input [15:0] cylinder;
        input [15:0] secthead;
        input [15:0] busdata;
        begin
            case (sel)
                `DESR_SEL_ENDING: begin
                    desr_pick = ending; // [R1]
                end
                `DESR_SEL_CYLINDER: begin
                    desr_pick = cylinder; // [R13]
                end
                `DESR_SEL_SECTHEAD: begin
                    desr_pick = secthead; // [R15]
                end
                `DESR_SEL_BUSDATA: begin
                    desr_pick = busdata; // [R16]
                end
                default: begin
                    desr_pick = `DESR_RST_PARCEL;
                end
            endcase
        end
    endfunction

    // ======================================================
    // Parcel selection
    // ======================================================
    // Sector and head parcel is built from the live inputs on every read
    reg [15:0] parcel_d;

    always @* begin
        parcel_d = desr_pick(status_select,
                             drive_ending_status_parcel,
                             id_parameter_zero_status,
                             desr_sect_head(sector_addr, head_addr,
                                            read_protect, write_protect),
                             {bus_a_in, bus_b_in});
    end

    // ======================================================
    // Accumulator transfer
    // ======================================================
    // The read path only samples; capture state has no read input at all
    reg [15:0] accum_data_d;
    reg        accum_valid_d;

    always @* begin
        accum_valid_d = status_read_function; // [R1]
        accum_data_d  = accum_data_q;
        if (status_read_function) begin
            accum_data_d = parcel_d; // [R17]
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            accum_data_q  <= `DESR_RST_PARCEL;
            accum_valid_q <= 1'b0;
        end else begin
            accum_data_q  <= accum_data_d;
            accum_valid_q <= accum_valid_d;
        end
    end

    // ======================================================
    // Ending status decode (status flags use the final byte of the parcel, done uses the capture)
    // ======================================================
    // Flags follow the low byte: on a single sequence it is the copied initial byte
    reg seq_done_d;
    reg op_exception_d;
    reg unsol_exception_d;
    reg cmd_pending_d;
    reg last_byte_invalid_d;
    reg parity_error_d;
    reg good_transfer_d;

    always @* begin
        seq_done_d          = capture_done;
        op_exception_d      = desr_op_match(final_status, `DESR_OP_EXCEPT); // [R8]
        unsol_exception_d   = desr_op_match(final_status, `DESR_OP_UNSOL); // [R8]
        cmd_pending_d       = final_status[`DESR_BIT_TIMEDEP]; // [R9]
        last_byte_invalid_d = final_status[`DESR_BIT_ODD]; // [R10]
        parity_error_d      = final_status[`DESR_BIT_PARITY]; // [R11]
        good_transfer_d     = final_status[`DESR_BIT_GOOD]; // [R12]
    end

    always @(posedge core_clk) begin
        if (reset) begin
            seq_done_q          <= 1'b0;
            op_exception_q      <= 1'b0;
            unsol_exception_q   <= 1'b0;
            cmd_pending_q       <= 1'b0;
            last_byte_invalid_q <= 1'b0;
            parity_error_q      <= 1'b0;
            good_transfer_q     <= 1'b0;
        end else begin
            seq_done_q          <= seq_done_d;
            op_exception_q      <= op_exception_d;
            unsol_exception_q   <= unsol_exception_d;
            cmd_pending_q       <= cmd_pending_d;
            last_byte_invalid_q <= last_byte_invalid_d;
            parity_error_q      <= parity_error_d;
            good_transfer_q     <= good_transfer_d;
        end
    end
endmodule

// file: verif/desr_readout_assertions.sv
// Concurrent checks on the status readout ports
`timescale 1ns/1ps
module desr_readout_assertions (
    // Clock and reset
    input wire        core_clk,
    input wire        reset,
    // Read request and select
    input wire        status_read_function,
    input wire [1:0]  status_select,
    // Sequencer and drive side
    input wire        seq_start,
    input wire        seq_dual,
    input wire        status_strobe,
    input wire [7:0]  bus_a_in,
    input wire [7:0]  bus_b_in,
    // Adapter address registers
    input wire [15:0] cylinder_reg,
    input wire [5:0]  sector_addr,
    input wire [4:0]  head_addr,
    input wire        read_protect,
    input wire        write_protect,
    // Outputs watched
    input wire [15:0] accum_data_q,
    input wire        accum_valid_q,
    input wire        op_exception_q,
    input wire        last_byte_invalid_q
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    wire rd = status_read_function;
    // ==========================================
    // Parcel answers and decoded flags
    property p_valid; rd |=> accum_valid_q; endproperty
    a_valid: assert property (p_valid) else $error("no valid");
    property p_hold; !rd |=> !accum_valid_q && $stable(accum_data_q); endproperty
    a_hold: assert property (p_hold) else $error("parcel moved");
    property p_cyl; rd && status_select == 2'h1 |=> accum_data_q == $past(cylinder_reg);
    endproperty
    a_cyl: assert property (p_cyl) else $error("bad cylinder");
    property p_sect; rd && status_select == 2'h2 |=> accum_data_q == {2'h0,
        $past(write_protect), $past(read_protect), 1'b0, $past(head_addr), $past(sector_addr)};
    endproperty
    a_sect: assert property (p_sect) else $error("bad sector");
    property p_bus; rd && status_select == 2'h3 |=> accum_data_q == {$past(bus_a_in),
        $past(bus_b_in)}; endproperty
    a_bus: assert property (p_bus) else $error("bad bus data");
    property p_init; seq_start ##1 (status_strobe && !seq_dual) ##1 (!status_strobe) [*2]
        ##1 (rd && status_select == 2'h0) |=> accum_data_q == {2{$past(bus_b_in, 4)}};
    endproperty
    a_init: assert property (p_init) else $error("bad single parcel");
    property p_exc; status_strobe |=> ##1 op_exception_q == ($past(bus_b_in[3:0], 2) == 4'h8);
    endproperty
    a_exc: assert property (p_exc) else $error("bad exception flag");
    property p_odd; status_strobe |=> ##1 last_byte_invalid_q == $past(bus_b_in[5], 2);
    endproperty
    a_odd: assert property (p_odd) else $error("bad odd flag");
    cover property (rd && status_select == 2'h0);
    cover property (status_strobe ##1 status_strobe);
    cover property (op_exception_q);
endmodule
bind desr_readout desr_readout_assertions u_chk (
    .core_clk             (core_clk),
    .reset                (reset),
    .status_read_function (status_read_function),
    .status_select        (status_select),
    .seq_start            (seq_start),
    .seq_dual             (seq_dual),
    .status_strobe        (status_strobe),
    .bus_a_in             (bus_a_in),
    .bus_b_in             (bus_b_in),
    .cylinder_reg         (cylinder_reg),
    .sector_addr          (sector_addr),
    .head_addr            (head_addr),
    .read_protect         (read_protect),
    .write_protect        (write_protect),
    .accum_data_q         (accum_data_q),
    .accum_valid_q        (accum_valid_q),
    .op_exception_q       (op_exception_q),
    .last_byte_invalid_q  (last_byte_invalid_q)
);

// file: verif/desr_drive_model.sv
// Disk drive stand-in returning ending status on bus B
`timescale 1ns/1ps
module desr_drive_model (
    // Clock
    input  wire       core_clk,
    // Drive buses
    output reg  [7:0] bus_a_in = 8'h00,
    output reg  [7:0] bus_b_in = 8'h00,
    output reg        status_strobe = 1'b0
);
    // Good transfer is always the inverse of a parity error
    function [7:0] status_byte(input [3:0] op, input tdep, odd, perr);
        status_byte = {~perr, perr, odd, tdep, op};
    endfunction
    task send(input [7:0] a, b);
        status_strobe = 1'b1;
        bus_a_in = a;
        bus_b_in = b;
        @(negedge core_clk);
    endtask
    // Released bus B shows the inverse so a stale byte never looks valid
    task idle;
        status_strobe = 1'b0;
        bus_b_in = ~bus_b_in;
    endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the status readout block
`timescale 1ns/1ps
`include "desr_map.vh"
module testbench;
    localparam [31:0] OPS = 32'hC8765410;
    reg         core_clk = 1'b0, reset = 1'b1, status_read_function = 1'b0;
    reg         seq_start = 1'b0, seq_dual = 1'b0, read_protect = 1'b0, write_protect = 1'b0;
    reg  [1:0]  status_select = 2'h0;
    reg  [15:0] cylinder_reg = 16'h0000;
    reg  [5:0]  sector_addr = 6'h00;
    reg  [4:0]  head_addr = 5'h00;
    reg  [7:0]  init_m, fin_m, s1;
    reg         done_m;
    reg  [15:0] exp_q[$];
    wire [7:0]  bus_a_in, bus_b_in;
    wire [15:0] accum_data_q;
    wire        status_strobe, accum_valid_q, seq_done_q, op_exception_q, unsol_exception_q;
    wire        cmd_pending_q, last_byte_invalid_q, parity_error_q, good_transfer_q;
    integer     fails = 0, check_count = 0, seed = 32'h960a5399, i, k;
    always #10 core_clk = ~core_clk;
    desr_readout i_desr_readout (
        .core_clk             (core_clk),
        .reset                (reset),
        .status_read_function (status_read_function),
        .status_select        (status_select),
        .seq_start            (seq_start),
        .seq_dual             (seq_dual),
        .status_strobe        (status_strobe),
        .bus_a_in             (bus_a_in),
        .bus_b_in             (bus_b_in),
        .cylinder_reg         (cylinder_reg),
        .sector_addr          (sector_addr),
        .head_addr            (head_addr),
        .read_protect         (read_protect),
        .write_protect        (write_protect),
        .accum_data_q         (accum_data_q),
        .accum_valid_q        (accum_valid_q),
        .seq_done_q           (seq_done_q),
        .op_exception_q       (op_exception_q),
        .unsol_exception_q    (unsol_exception_q),
        .cmd_pending_q        (cmd_pending_q),
        .last_byte_invalid_q  (last_byte_invalid_q),
        .parity_error_q       (parity_error_q),
        .good_transfer_q      (good_transfer_q)
    );
    desr_drive_model drive (
        .core_clk      (core_clk),
        .bus_a_in      (bus_a_in),
        .bus_b_in      (bus_b_in),
        .status_strobe (status_strobe)
    );
    task check(input [15:0] got, input [15:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task check_flag(input got, input exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED %0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    // Decoded flags are expected from the last byte stored in the low half
    task check_status;
        check_flag(op_exception_q, fin_m[`DESR_OP_HI:`DESR_OP_LO] == `DESR_OP_EXCEPT);
        check_flag(unsol_exception_q, fin_m[`DESR_OP_HI:`DESR_OP_LO] == `DESR_OP_UNSOL);
        check_flag(cmd_pending_q, fin_m[`DESR_BIT_TIMEDEP]);
        check_flag(last_byte_invalid_q, fin_m[`DESR_BIT_ODD]);
        check_flag(parity_error_q, fin_m[`DESR_BIT_PARITY]);
        check_flag(good_transfer_q, fin_m[`DESR_BIT_GOOD]);
    endtask
    // Task raises the request and leaves it high between back-to-back reads; caller drops it after the last
    task read(input [1:0] sel);
        status_read_function = 1'b1;
        status_select = sel;
        {cylinder_reg, sector_addr, head_addr} = {$random(seed)};
        {read_protect, write_protect} = $random(seed);
        case (sel)
            2'h0: exp_q.push_back({init_m, fin_m});
            2'h1: exp_q.push_back(cylinder_reg);
            2'h2: exp_q.push_back({2'h0, write_protect, read_protect, 1'b0, head_addr,
                                   sector_addr});
            default: exp_q.push_back({bus_a_in, bus_b_in});
        endcase
        @(negedge core_clk);
        check_flag(accum_valid_q, 1'b1);
        check(accum_data_q, exp_q.pop_front());
    endtask
    task complete_run;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================
    // Sequences with every operation code, single, dual and cut short
    initial begin
        repeat (12) @(negedge core_clk);
        reset = 1'b0;
        for (i = 0; i < 32; i = i + 1) begin
            seq_start = 1'b1;
            seq_dual = $random(seed);
            @(negedge core_clk);
            seq_start = 1'b0;
            s1 = drive.status_byte(OPS[4 * (i % 8) +: 4], $random(seed), $random(seed),
                                   $random(seed));
            drive.send($random(seed), s1);
            init_m = s1;
            fin_m = s1;
            done_m = !seq_dual;
            if (seq_dual && i % 3 != 0) begin
                fin_m = $random(seed);
                done_m = 1'b1;
                drive.send($random(seed), fin_m);
            end
            drive.idle();
            @(negedge core_clk);
            check_flag(seq_done_q, done_m);
            @(negedge core_clk);
            check_status;
            for (k = 0; k < 5; k = k + 1) read(k[1:0]);
            status_read_function = 1'b0;
            $display("test %0d done", i);
        end
        // Mid-run reset: stored bytes and every flag go back to zero
        reset = 1'b1;
        repeat (2) @(negedge core_clk);
        init_m = `DESR_RST_STATUS;
        fin_m = `DESR_RST_STATUS;
        check_flag(accum_valid_q, 1'b0);
        check(accum_data_q, `DESR_RST_PARCEL);
        check_flag(seq_done_q, 1'b0);
        check_status;
        reset = 1'b0;
        read(2'h0);
        status_read_function = 1'b0;
        $display("reset test done");
        complete_run;
    end
    initial begin
        #200000;
        fails = fails + 1;
        complete_run;
    end
endmodule
